// ==== include/interval_timebase_timer_consts.svh ====
// Offsets, field positions, reset values and prescaler taps of the interval/time-base timer
`ifndef INTERVAL_TIMEBASE_TIMER_CONSTS_SVH
`define INTERVAL_TIMEBASE_TIMER_CONSTS_SVH

// ====================================================================
// Register byte offsets (low address byte only)
`define ITT_OFF_MODE 8'h00
`define ITT_OFF_COUNT 8'h04
`define ITT_OFF_PORT_MODE 8'h08
`define ITT_OFF_IRQ_REQ 8'h0C
`define ITT_OFF_IRQ_EN 8'h10

// ====================================================================
// Reset values and counter maximum
`define ITT_MODE_RESET 8'h10
`define ITT_COUNT_RESET 8'h00
`define ITT_COUNT_MAX 8'hFF

// ====================================================================
// Field positions
`define ITT_MODE_OUTSEL_HI 7
`define ITT_MODE_OUTSEL_LO 5
`define ITT_MODE_RSVD_BIT 4
`define ITT_MODE_FUNC_BIT 3
`define ITT_MODE_CLR_BIT 2
`define ITT_PORT_CLKOUT_BIT 0
`define ITT_IRQ_OVF_BIT 0

// ====================================================================
// Bus constants
`define ITT_HSIZE_WORD 3'h2
`define ITT_HRESP_OKAY 1'b0

// ====================================================================
// Prescaler widths and tap masks
`define ITT_SYS_PRESC_W 13
`define ITT_WATCH_PRESC_W 7
`define ITT_SYS_MASK_8192 13'h1FFF
`define ITT_SYS_MASK_4096 13'h0FFF
`define ITT_SYS_MASK_2048 13'h07FF
`define ITT_SYS_MASK_512 13'h01FF
`define ITT_SYS_MASK_256 13'h00FF
`define ITT_SYS_MASK_128 13'h007F
`define ITT_SYS_MASK_32 13'h001F
`define ITT_SYS_MASK_8 13'h0007
`define ITT_WATCH_MASK_1S 7'h7F
`define ITT_WATCH_MASK_HALF 7'h3F
`define ITT_WATCH_MASK_QUARTER 7'h1F
`define ITT_WATCH_MASK_32ND 7'h03

`endif

// ==== include/timer_types_pkg.sv ====
// Types shared by the interval/time-base timer modules
package timer_types_pkg;

    // ================================================================
    // Power modes, Gray coded along active-sleep-subactive-subsleep-watch-standby
    typedef enum logic [2:0]
    {
        PM_ACTIVE = 3'h0,
        PM_SLEEP = 3'h1,
        PM_SUBACTIVE = 3'h3,
        PM_SUBSLEEP = 3'h2,
        PM_WATCH = 3'h6,
        PM_STANDBY = 3'h7
    } power_mode_t;

    // ================================================================
    // Clock output selections
    typedef enum logic [2:0]
    {
        OUT_SYS_32 = 3'h0,
        OUT_SYS_16 = 3'h1,
        OUT_SYS_8 = 3'h2,
        OUT_SYS_4 = 3'h3,
        OUT_WATCH_32 = 3'h4,
        OUT_WATCH_16 = 3'h5,
        OUT_WATCH_8 = 3'h6,
        OUT_WATCH_4 = 3'h7
    } out_sel_t;

endpackage : timer_types_pkg

// ==== include/watch_presc_if.sv ====
// Link between the timer core and its watch-clock prescaler
`include "interval_timebase_timer_consts.svh"

interface watch_presc_if;
    logic raw_level;
    logic clear;
    logic run;
    logic [`ITT_WATCH_PRESC_W-1:0] value;
    logic tick;

    modport ctrl
    (
        output raw_level,
        output clear,
        output run,
        input value,
        input tick
    );

    modport presc
    (
        input raw_level,
        input clear,
        input run,
        output value,
        output tick
    );
endinterface : watch_presc_if

// ==== logic/interval_timebase_timer.sv ====
// Interval timer / clock time base with overflow interrupt and clock output pin
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`include "interval_timebase_timer_consts.svh"

module interval_timebase_timer
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Chip state and watch clock
    input wire logic [2:0] i_power_mode,
    input wire logic i_watch_clk,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Interrupt and clock output pin
    output logic o_irq,
    output logic o_clock_output_pin
);

    timer_types_pkg::power_mode_t pmode;
    timer_types_pkg::out_sel_t out_sel;

    logic [7:0] timer_a_mode_reg_ff;
    logic [7:0] timer_a_count_value_ff;
    logic [`ITT_SYS_PRESC_W-1:0] system_prescaler_ff;
    logic overflow_request_flag_ff;
    logic overflow_irq_enable_ff;
    logic clock_output_en_ff;
    logic clock_output_pin_ff;
    logic irq_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;

    logic addr_phase;
    logic rd_access;
    logic rd_clear;
    logic mode_wr_ok;
    logic sys_run;
    logic watch_avail;
    logic sys_tick;
    logic watch_match;
    logic count_tick;
    logic overflow;
    logic tb_clear;
    logic function_select_bit;
    logic nxt_flag;
    logic nxt_pin;
    logic [`ITT_SYS_PRESC_W-1:0] sys_mask;
    logic [`ITT_WATCH_PRESC_W-1:0] watch_mask;
    logic [31:0] nxt_rdata;

    watch_presc_if wp ();

    // ================================================================
    // Decode of chip state
    assign pmode = timer_types_pkg::power_mode_t'(i_power_mode);
    assign out_sel = timer_types_pkg::out_sel_t'(
        timer_a_mode_reg_ff[`ITT_MODE_OUTSEL_HI:`ITT_MODE_OUTSEL_LO]);
    // System clock only exists in active and sleep
    assign sys_run = (pmode == timer_types_pkg::PM_ACTIVE) ||
                     (pmode == timer_types_pkg::PM_SLEEP);
    assign watch_avail = sys_run || (pmode == timer_types_pkg::PM_SUBACTIVE);
    // CPU only executes, and so only writes mode, in active or subactive
    assign mode_wr_ok = (pmode == timer_types_pkg::PM_ACTIVE) ||
                        (pmode == timer_types_pkg::PM_SUBACTIVE);

    assign function_select_bit = timer_a_mode_reg_ff[`ITT_MODE_FUNC_BIT];
    assign tb_clear = function_select_bit & timer_a_mode_reg_ff[`ITT_MODE_CLR_BIT];

    // ================================================================
    // Watch prescaler; the watch clock pin needs the board oscillator
    assign wp.raw_level = i_watch_clk;
    assign wp.clear = tb_clear;
    assign wp.run = (pmode != timer_types_pkg::PM_STANDBY);

    watch_prescaler u_watch_prescaler
    (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .wp(wp)
    );

    // ================================================================
    // System prescaler: free running while the system clock is alive
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            system_prescaler_ff <= '0;
        end
        else if (i_clk_en && sys_run)
        begin
            system_prescaler_ff <= system_prescaler_ff + 1'b1;
        end
    end

    // Interval tap: a tap ticks when all bits below it are ones
    always_comb
    begin
        sys_mask = `ITT_SYS_MASK_8192;
        case (timer_a_mode_reg_ff[2:0])
            3'h0: sys_mask = `ITT_SYS_MASK_8192;
            3'h1: sys_mask = `ITT_SYS_MASK_4096;
            3'h2: sys_mask = `ITT_SYS_MASK_2048;
            3'h3: sys_mask = `ITT_SYS_MASK_512;
            3'h4: sys_mask = `ITT_SYS_MASK_256;
            3'h5: sys_mask = `ITT_SYS_MASK_128;
            3'h6: sys_mask = `ITT_SYS_MASK_32;
            3'h7: sys_mask = `ITT_SYS_MASK_8;
            default: sys_mask = `ITT_SYS_MASK_8192;
        endcase
    end

    // Time-base tap: period over 256 counts gives 1 s .. 1/32 s
    always_comb
    begin
        watch_mask = `ITT_WATCH_MASK_1S;
        case (timer_a_mode_reg_ff[1:0])
            2'h0: watch_mask = `ITT_WATCH_MASK_1S;
            2'h1: watch_mask = `ITT_WATCH_MASK_HALF;
            2'h2: watch_mask = `ITT_WATCH_MASK_QUARTER;
            2'h3: watch_mask = `ITT_WATCH_MASK_32ND;
            default: watch_mask = `ITT_WATCH_MASK_1S;
        endcase
    end

    assign sys_tick = sys_run && ((system_prescaler_ff & sys_mask) == sys_mask);
    assign watch_match = wp.tick && ((wp.value & watch_mask) == watch_mask);

    // Function bit picks the source of the counting clock
    assign count_tick = function_select_bit ? watch_match : sys_tick;
    assign overflow = count_tick && !tb_clear &&
                      (timer_a_count_value_ff == `ITT_COUNT_MAX);

    // ================================================================
    // Counter: hardware only, software cannot write it
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            timer_a_count_value_ff <= `ITT_COUNT_RESET;
        end
        else if (i_clk_en)
        begin
            if (tb_clear)
            begin
                timer_a_count_value_ff <= `ITT_COUNT_RESET;
            end
            else if (count_tick)
            begin
                // 0xFF rolls to 0x00 and keeps going
                timer_a_count_value_ff <= timer_a_count_value_ff + 8'h01;
            end
        end
    end

    // ================================================================
    // AHB-Lite address phase; only whole-word writes are honoured
    assign addr_phase = i_hsel && i_hready && i_htrans[1];
    assign rd_access = addr_phase && !i_hwrite;
    assign rd_clear = rd_access && (i_haddr[7:0] == `ITT_OFF_IRQ_REQ);

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else if (i_clk_en)
        begin
            wr_pend_ff <= addr_phase && i_hwrite && (i_hsize == `ITT_HSIZE_WORD);
            wr_addr_ff <= i_haddr[7:0];
        end
    end

    // Read mux, sampled at the address phase; unmapped reads give zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (i_haddr[7:0])
            `ITT_OFF_MODE:
                nxt_rdata[7:0] = timer_a_mode_reg_ff | 8'h10;
            `ITT_OFF_COUNT:
                // Subactive reads are not supported and return zero
                nxt_rdata[7:0] = (pmode == timer_types_pkg::PM_SUBACTIVE) ?
                                 8'h00 : timer_a_count_value_ff;
            `ITT_OFF_PORT_MODE:
                nxt_rdata[`ITT_PORT_CLKOUT_BIT] = clock_output_en_ff;
            `ITT_OFF_IRQ_REQ:
                nxt_rdata[`ITT_IRQ_OVF_BIT] = overflow_request_flag_ff;
            `ITT_OFF_IRQ_EN:
                nxt_rdata[`ITT_IRQ_OVF_BIT] = overflow_irq_enable_ff;
            default:
                nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Zero wait states, always OKAY
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= `ITT_HRESP_OKAY;
        end
        else if (i_clk_en)
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= `ITT_HRESP_OKAY;
            if (rd_access)
            begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    // ================================================================
    // Mode register; reserved bit 4 stays one whatever is written
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            timer_a_mode_reg_ff <= `ITT_MODE_RESET;
        end
        else if (i_clk_en && wr_pend_ff && mode_wr_ok &&
                 (wr_addr_ff == `ITT_OFF_MODE))
        begin
            timer_a_mode_reg_ff <= i_hwdata[7:0] | 8'h10;
        end
    end

    // Port mode and interrupt enable registers
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            clock_output_en_ff <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
        end
        else if (i_clk_en && wr_pend_ff)
        begin
            if (wr_addr_ff == `ITT_OFF_PORT_MODE)
            begin
                clock_output_en_ff <= i_hwdata[`ITT_PORT_CLKOUT_BIT];
            end
            if (wr_addr_ff == `ITT_OFF_IRQ_EN)
            begin
                overflow_irq_enable_ff <= i_hwdata[`ITT_IRQ_OVF_BIT];
            end
        end
    end

    // ================================================================
    // Sticky overflow flag: an overflow in the clearing cycle wins
    always_comb
    begin
        nxt_flag = overflow_request_flag_ff;
        if (overflow)
        begin
            nxt_flag = 1'b1;
        end
        else if (rd_clear)
        begin
            nxt_flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            overflow_request_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            overflow_request_flag_ff <= nxt_flag;
            irq_ff <= nxt_flag & overflow_irq_enable_ff;
        end
    end

    // ================================================================
    // Clock output: square waves taken from prescaler bits
    always_comb
    begin
        nxt_pin = 1'b0;
        case (out_sel)
            timer_types_pkg::OUT_SYS_32: nxt_pin = sys_run & system_prescaler_ff[4];
            timer_types_pkg::OUT_SYS_16: nxt_pin = sys_run & system_prescaler_ff[3];
            timer_types_pkg::OUT_SYS_8: nxt_pin = sys_run & system_prescaler_ff[2];
            timer_types_pkg::OUT_SYS_4: nxt_pin = sys_run & system_prescaler_ff[1];
            timer_types_pkg::OUT_WATCH_32: nxt_pin = watch_avail & wp.value[4];
            timer_types_pkg::OUT_WATCH_16: nxt_pin = watch_avail & wp.value[3];
            timer_types_pkg::OUT_WATCH_8: nxt_pin = watch_avail & wp.value[2];
            timer_types_pkg::OUT_WATCH_4: nxt_pin = watch_avail & wp.value[1];
            default: nxt_pin = 1'b0;
        endcase
    end

    // Pin idles low when disabled; registered to keep it glitch free
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            clock_output_pin_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            clock_output_pin_ff <= clock_output_en_ff & nxt_pin;
        end
    end

    // ================================================================
    // Outputs straight from flip-flops
    assign o_hrdata = hrdata_ff;
    assign o_hreadyout = hreadyout_ff;
    assign o_hresp = hresp_ff;
    assign o_irq = irq_ff;
    assign o_clock_output_pin = clock_output_pin_ff;

endmodule : interval_timebase_timer

// ==== logic/watch_prescaler.sv ====
// Watch clock synchroniser and watch prescaler
`include "interval_timebase_timer_consts.svh"

module watch_prescaler
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Core link
    watch_presc_if.presc wp
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic [`ITT_WATCH_PRESC_W-1:0] value_ff;
    logic rise;

    // ================================================================
    // Two-stage synchroniser; only sync2 is looked at downstream
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sync1_ff <= wp.raw_level;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // One tick per watch clock rise, dead while cleared or stopped
    assign rise = sync2_ff & ~prev_ff;
    assign wp.tick = rise & wp.run & ~wp.clear;

    // ================================================================
    // Prescaler count, held at zero while the clear bits are set
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            value_ff <= '0;
        end
        else if (i_clk_en)
        begin
            if (wp.clear)
            begin
                value_ff <= '0;
            end
            else if (wp.tick)
            begin
                value_ff <= value_ff + 1'b1;
            end
        end
    end

    assign wp.value = value_ff;

endmodule : watch_prescaler

// ==== tb/interval_timebase_timer_chk.sv ====
// Port-level checker of the interval/time-base timer
`include "interval_timebase_timer_consts.svh"

module interval_timebase_timer_chk
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Chip state and watch clock
    input wire logic [2:0] i_power_mode,
    input wire logic i_watch_clk,
    // Bus
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Interrupt and pin
    input wire logic o_irq,
    input wire logic o_clock_output_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================
    // Read address phase taken at this edge
    logic rd;
    logic [7:0] a;
    assign rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_clk_en;
    assign a = i_haddr[7:0];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ====================================
    // Bus answer never stalls or errors
    AST_READY: assert property (o_hreadyout)
        else $error("hreadyout low");
    AST_OKAY: assert property (!o_hresp)
        else $error("hresp not okay");
    // Outputs quiet at the first edge after reset
    AST_RST_OUT: assert property ($past(!i_reset_n) |-> !o_irq && !o_clock_output_pin
        && o_hrdata == 32'h0000_0000) else $error("outputs not quiet after reset");
    // Register reads
    AST_MODE_RD: assert property (rd && a == `ITT_OFF_MODE |=> o_hrdata[4]
        && o_hrdata[31:8] == 24'h00_0000) else $error("mode read wrong");
    AST_CNT_W: assert property (rd && a == `ITT_OFF_COUNT |=> o_hrdata[31:8] == 24'h00_0000)
        else $error("count wider than 8 bits");
    AST_SUB_RD: assert property (rd && a == `ITT_OFF_COUNT
        && i_power_mode == timer_types_pkg::PM_SUBACTIVE |=> o_hrdata == 32'h0000_0000)
        else $error("count readable in subactive");
    AST_IRQ_RD: assert property (rd && a == `ITT_OFF_IRQ_REQ && o_irq |=> o_hrdata[0])
        else $error("irq without flag");
    // Reading the flag drops the request at the next edge; the check looks two edges later
    AST_IRQ_CLR: assert property (rd && a == `ITT_OFF_IRQ_REQ |=> ##1 !o_irq)
        else $error("irq not cleared by read");
    // No divided clock reaches the pin in the stopped modes
    AST_PIN_OFF: assert property ($past(i_power_mode) inside {timer_types_pkg::PM_WATCH,
        timer_types_pkg::PM_STANDBY, timer_types_pkg::PM_SUBSLEEP} |-> !o_clock_output_pin)
        else $error("pin toggles in stopped mode");
endmodule : interval_timebase_timer_chk

bind interval_timebase_timer interval_timebase_timer_chk u_chk (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_power_mode(i_power_mode),
    .i_watch_clk(i_watch_clk), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq),
    .o_clock_output_pin(o_clock_output_pin));

// ==== tb/testbench.sv ====
// Self-checking bench of the interval/time-base timer
`include "interval_timebase_timer_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================
    // Stimulus, observed signals, tallies
    localparam logic [7:0] A_MODE = `ITT_OFF_MODE;
    localparam logic [7:0] A_CNT = `ITT_OFF_COUNT;
    localparam logic [7:0] A_REQ = `ITT_OFF_IRQ_REQ;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_clk_en = 1'b1;
    logic [2:0] i_power_mode = timer_types_pkg::PM_ACTIVE;
    logic i_watch_clk = 1'b0;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0000_0000;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = `ITT_HSIZE_WORD;
    logic [31:0] i_hwdata = 32'h0000_0000;
    logic i_hready;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic o_irq;
    logic o_clock_output_pin;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int dv[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    int wp[4] = '{128, 64, 32, 4};
    assign i_hready = o_hreadyout;

    // System clock 20 MHz; watch clock sped up, unrelated in phase, to keep the run short
    initial forever #25 i_clk = ~i_clk;
    initial forever #410 i_watch_clk = ~i_watch_clk;

    interval_timebase_timer uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
        .i_power_mode(i_power_mode), .i_watch_clk(i_watch_clk), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq),
        .o_clock_output_pin(o_clock_output_pin));

    // ====================================
    // Verdict, comparisons, cycle ceiling
    task print_verdict;
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
        check_count++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1))
        begin
            n_fail++;
            $display("BAD %s exp %0d..%0d got %h", nm, lo, hi, g);
        end
    endtask : chk_rng

    // Counter updates by NBA so tasks read a stable cycle number
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    // ====================================
    // Bus cycles: address phase held until ready, then data phase
    task ap(input logic [7:0] a, input logic w);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr <= {24'h00_0000, a};
        i_hwrite <= w;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'b00;
    endtask : ap

    task dp;
        do @(posedge i_clk); while (i_hready !== 1'b1);
    endtask : dp

    task wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, 1'b1);
        i_hwdata <= d;
        dp();
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] g);
        ap(a, 1'b0);
        dp();
        g = o_hrdata;
    endtask : rd

    task pm(input logic [2:0] m);
        @(posedge i_clk);
        i_power_mode <= m;
    endtask : pm

    task wedge(input int n);
        repeat (n) @(posedge i_watch_clk);
    endtask : wedge

    task wirq;
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_irq !== 1'b1 && n < 3000);
    endtask : wirq

    // Rising edges of the pin over 1312 cycles, which is 80 watch periods
    task edges(output logic [31:0] g);
        logic p;
        g = 32'h0000_0000;
        // Let the registered pin settle after a mode or enable change
        repeat (2) @(posedge i_clk);
        p = o_clock_output_pin;
        repeat (1312)
        begin
            @(posedge i_clk);
            if (o_clock_output_pin === 1'b1 && p !== 1'b1)
                g++;
            p = o_clock_output_pin;
        end
    endtask : edges

    // ====================================
    // Scenarios
    task t_reset;
        logic [31:0] g;
        rd(A_MODE, g);
        chk("mode", 32'h0000_0010, g);
        rd(A_CNT, g);
        chk("count", 32'h0000_0000, g);
        wr(A_MODE, 32'h0000_00EF);
        rd(A_MODE, g);
        chk("mode", 32'h0000_00FF, g);
        wr(A_MODE, 32'h0000_000C);
        wr(A_CNT, 32'h0000_00AA);
        wedge(8);
        rd(A_CNT, g);
        chk("held count", 32'h0000_0000, g);
    endtask : t_reset

    // Reads spaced by two ticks of each tap; then a halt in watch mode
    task t_int;
        logic [31:0] a;
        logic [31:0] b;
        for (int c = 0; c < 8; c++)
        begin
            wr(A_MODE, {29'h0000_0000, c[2:0]});
            rd(A_CNT, a);
            repeat (2 * dv[c] - 3) @(posedge i_clk);
            rd(A_CNT, b);
            chk("ticks", 32'h0000_0002, {24'h00_0000, b[7:0] - a[7:0]});
        end
        rd(A_CNT, a);
        pm(timer_types_pkg::PM_WATCH);
        repeat (400) @(posedge i_clk);
        pm(timer_types_pkg::PM_ACTIVE);
        rd(A_CNT, b);
        chk_rng("halt", 0, 1, {24'h00_0000, b[7:0] - a[7:0]});
    endtask : t_int

    task t_irq;
        int t;
        logic [31:0] g;
        wr(`ITT_OFF_IRQ_EN, 32'h0000_0001);
        wr(A_MODE, 32'h0000_000C);
        wr(A_MODE, 32'h0000_0007);
        rd(A_REQ, g);
        wirq();
        t = cyc;
        rd(A_REQ, g);
        chk("flag", 32'h0000_0001, g);
        rd(A_CNT, g);
        chk_rng("wrap", 0, 3, g);
        chk("irq", 32'h0000_0000, {31'h0000_0000, o_irq});
        wirq();
        chk("period", 32'h0000_0800, cyc - t);
        rd(A_REQ, g);
        wr(`ITT_OFF_IRQ_EN, 32'h0000_0000);
        repeat (2100) @(posedge i_clk);
        chk("masked irq", 32'h0000_0000, {31'h0000_0000, o_irq});
        rd(A_REQ, g);
        chk("masked flag", 32'h0000_0001, g);
    endtask : t_irq

    // Three and a half periods of each watch tap give a count of three
    task t_tb;
        logic [31:0] a;
        logic [31:0] b;
        for (int c = 0; c < 4; c++)
        begin
            wr(A_MODE, 32'h0000_000C);
            wr(A_MODE, {30'h0000_0002, c[1:0]});
            wedge(wp[c] * 7 / 2);
            rd(A_CNT, a);
            chk("base count", 32'h0000_0003, a);
        end
        rd(A_CNT, a);
        pm(timer_types_pkg::PM_WATCH);
        wedge(40);
        pm(timer_types_pkg::PM_ACTIVE);
        rd(A_CNT, b);
        chk_rng("watch run", 9, 11, b - a);
        rd(A_CNT, a);
        pm(timer_types_pkg::PM_STANDBY);
        wedge(40);
        pm(timer_types_pkg::PM_ACTIVE);
        rd(A_CNT, b);
        chk_rng("standby", 0, 1, b - a);
        pm(timer_types_pkg::PM_SUBACTIVE);
        rd(A_CNT, a);
        chk("sub read", 32'h0000_0000, a);
        pm(timer_types_pkg::PM_ACTIVE);
    endtask : t_tb

    task t_out;
        int e;
        logic [31:0] g;
        wr(`ITT_OFF_PORT_MODE, 32'h0000_0001);
        for (int s = 0; s < 8; s++)
        begin
            wr(A_MODE, {24'h00_0000, s[2:0], 5'h07});
            edges(g);
            e = (s < 4) ? 1312 / (32 >> s) : 80 / (32 >> (s - 4));
            chk_rng("pin", e - 1, e + 1, g);
        end
        wr(`ITT_OFF_PORT_MODE, 32'h0000_0000);
        edges(g);
        chk("pin off", 32'h0000_0000, g);
        wr(`ITT_OFF_PORT_MODE, 32'h0000_0001);
        pm(timer_types_pkg::PM_SUBACTIVE);
        edges(g);
        chk_rng("sub watch pin", 19, 21, g);
        wr(A_MODE, 32'h0000_0067);
        edges(g);
        chk("sub sys pin", 32'h0000_0000, g);
        // Watch taps are gone in watch mode even with the pin enabled
        wr(A_MODE, 32'h0000_00E7);
        pm(timer_types_pkg::PM_WATCH);
        edges(g);
        chk("watch pin", 32'h0000_0000, g);
        pm(timer_types_pkg::PM_ACTIVE);
    endtask : t_out

    // Main sequence
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_int();
        t_irq();
        t_tb();
        t_out();
        print_verdict();
    end
endmodule : testbench
